// ---- pkg/tcr_params.svh ----
// constants for the calibration result and combined measurement block
`ifndef TCR_PARAMS_SVH
`define TCR_PARAMS_SVH
// ------------------------------------------------------------
// register map
// ------------------------------------------------------------
`define TCR_ADDR_CAL_FIRST 6'h1b
`define TCR_ADDR_CAL_SECOND 6'h1c
`define TCR_ADDR_W 6
`define TCR_WORD_W 24
`define TCR_VAL_W 23
`define TCR_PARITY_BIT 23
`define TCR_RESET_WORD 24'h000000
// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define TCR_CLK_PS 8000
`define TCR_MIN_SINGLE_PS 12000
`define TCR_MIN_SINGLE_CYC ((`TCR_MIN_SINGLE_PS + `TCR_CLK_PS - 1) / `TCR_CLK_PS)
`define TCR_COMBINED_MIN_PS 250
`define TCR_AVG_MAX 128
`endif

// ---- pkg/tcr_pkg.sv ----
// types shared by the calibration result block
package tcr_pkg;
	typedef enum logic [1:0] {TCR_IDLE, TCR_REF, TCR_RUN} tcr_state_t;
	typedef logic [23:0] tcr_word_t;
endpackage

// ---- verilog/tcr_chan.sv ----
// one converter channel: counts reference-to-end interval in clock cycles
`include "tcr_params.svh"
`timescale 1ns/1ps
`default_nettype none
module tcr_chan
	import tcr_pkg::*;
#(
	parameter int CNT_W = 23
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic en_i,
	input wire logic begin_i,
	input wire logic end_i,
	output logic done_o,
	output logic [CNT_W-1:0] count_o
);
	// refuse counter widths that the result word cannot carry
	if (CNT_W < 2 || CNT_W > 23) begin : g_bad_cnt_w
		$error("bad CNT_W");
	end
	// ------------------------------------------------------------
	// interval counter
	// ------------------------------------------------------------
	logic run_q; // measuring between begin and end
	logic [CNT_W-1:0] cnt_q; // running count
	wire [CNT_W-1:0] cnt_inc = cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
	// begin restarts, end latches the interval
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			run_q <= 1'b0;
			cnt_q <= '0;
			done_o <= 1'b0;
			count_o <= '0;
		end else if (en_i) begin
			done_o <= 1'b0;
			if (begin_i) begin
				run_q <= 1'b1;
				cnt_q <= '0;
			end else if (run_q && end_i) begin
				run_q <= 1'b0;
				done_o <= 1'b1;
				count_o <= cnt_inc;
			end else if (run_q) begin
				cnt_q <= cnt_inc;
			end
		end
	end
endmodule
`default_nettype wire

// ---- verilog/tcr_top.sv ----
// calibration result registers and combined two-channel measurement
// ------------------------------------------------------------
// ------------------------------------------------------------
`include "tcr_params.svh"
`timescale 1ns/1ps
`default_nettype none
module tcr_top
	import tcr_pkg::*;
#(
	parameter int AVG_LOG2 = 7 // log2 of max averaging samples
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire logic channel_one_begin_input_i,
	input wire logic channel_two_begin_input_i,
	input wire logic channel_one_end_input_i,
	input wire logic channel_two_end_input_i,
	input wire logic [2:0] avg_sel_i, // samples = 2**avg_sel_i, capped at 2**AVG_LOG2
	input wire logic channel_chip_select_n_i, // active low select
	input wire logic rd_i,
	input wire logic wr_i,
	input wire logic [5:0] addr_i,
	input wire logic [23:0] wdata_i,
	output logic [23:0] rdata_o,
	output logic rvalid_o,
	output logic ref_late_o, // reference begin too close to flight begin
	output logic cal_update_o
);
	// refuse averaging depths the 8-bit sample counter cannot hold
	if (AVG_LOG2 < 1 || AVG_LOG2 > 7) begin : g_bad_avg
		$error("AVG_LOG2 out of range");
	end
	// ------------------------------------------------------------
	// channels sharing one reference begin
	// ------------------------------------------------------------
	logic d1, d2;
	logic [22:0] c1, c2;
	// begins are tied together outside; either edge restarts both
	wire ref_begin = channel_one_begin_input_i | channel_two_begin_input_i;
	tcr_chan #(.CNT_W(23)) u_ch1 (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .en_i(ce_i),
		.begin_i(ref_begin), .end_i(channel_one_end_input_i),
		.done_o(d1), .count_o(c1));
	tcr_chan #(.CNT_W(23)) u_ch2 (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .en_i(ce_i),
		.begin_i(ref_begin), .end_i(channel_two_end_input_i),
		.done_o(d2), .count_o(c2));
	// ------------------------------------------------------------
	// reference lead check
	// ------------------------------------------------------------
	// counts cycles since reference; flight begin sooner than the lead is flagged
	logic [7:0] lead_q;
	wire [7:0] lead_min = 8'(`TCR_MIN_SINGLE_CYC);
	// lead_q reads k-1 at the k-th edge after the reference; a same-edge begin is no lead
	wire lead_short = channel_one_end_input_i && (ref_begin || (lead_q < lead_min - 8'h01));
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			lead_q <= 8'hff;
			ref_late_o <= 1'b0;
		end else if (ce_i) begin
			if (ref_begin) lead_q <= 8'h00;
			else if (lead_q != 8'hff) lead_q <= lead_q + 8'h01;
			ref_late_o <= lead_short;
		end
	end
	// ------------------------------------------------------------
	// averaging accumulators
	// ------------------------------------------------------------
	// both intervals accumulate; the host does the subtraction
	logic got1_q, got2_q;
	logic [29:0] acc1_q, acc2_q;
	logic [7:0] smp_q;
	wire [2:0] sel = (avg_sel_i > 3'(AVG_LOG2)) ? 3'(AVG_LOG2) : avg_sel_i;
	wire [7:0] target = 8'h01 << sel;
	wire pair = (got1_q | d1) & (got2_q | d2);
	wire last = pair && (smp_q + 8'h01 >= target);
	wire [29:0] sum1 = acc1_q + 30'(c1);
	wire [29:0] sum2 = acc2_q + 30'(c2);
	wire [22:0] avg1 = 23'(sum1 >> sel);
	wire [22:0] avg2 = 23'(sum2 >> sel);
	// parity over the 23-bit value, even overall
	wire [23:0] word1 = {^avg1, avg1};
	wire [23:0] word2 = {^avg2, avg2};
	tcr_word_t cal1_q, cal2_q;
	// finished averages land in the calibration words
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			got1_q <= 1'b0;
			got2_q <= 1'b0;
			acc1_q <= '0;
			acc2_q <= '0;
			smp_q <= 8'h00;
			cal1_q <= `TCR_RESET_WORD;
			cal2_q <= `TCR_RESET_WORD;
			cal_update_o <= 1'b0;
		end else if (ce_i) begin
			cal_update_o <= last;
			if (pair) begin
				got1_q <= 1'b0;
				got2_q <= 1'b0;
				acc1_q <= last ? '0 : acc1_q + 30'(c1);
				acc2_q <= last ? '0 : acc2_q + 30'(c2);
				smp_q <= last ? 8'h00 : smp_q + 8'h01;
				if (last) begin
					cal1_q <= word1;
					cal2_q <= word2;
				end
			end else begin
				got1_q <= got1_q | d1;
				got2_q <= got2_q | d2;
			end
		end
	end
	// ------------------------------------------------------------
	// register read port
	// ------------------------------------------------------------
	// write strobe is accepted and dropped; reads have no side effect
	wire sel_ok = !channel_chip_select_n_i && rd_i;
	wire [23:0] rd_mux = (addr_i == `TCR_ADDR_CAL_FIRST) ? cal1_q :
		(addr_i == `TCR_ADDR_CAL_SECOND) ? cal2_q : 24'h000000;
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_o <= 24'h000000;
			rvalid_o <= 1'b0;
		end else if (ce_i) begin
			rvalid_o <= sel_ok;
			if (sel_ok) rdata_o <= rd_mux;
		end
	end
	wire unused_ok = ^{wr_i, wdata_i};
	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	property p_read_first;
		@(posedge clk_i) disable iff (!rst_n_i)
		(ce_i && sel_ok && addr_i == `TCR_ADDR_CAL_FIRST) |=> (rdata_o == $past(cal1_q));
	endproperty
	a_read_first: assert property (p_read_first) else $error("first cal read wrong");
	property p_read_second;
		@(posedge clk_i) disable iff (!rst_n_i)
		(ce_i && sel_ok && addr_i == `TCR_ADDR_CAL_SECOND) |=> (rdata_o == $past(cal2_q));
	endproperty
	a_read_second: assert property (p_read_second) else $error("second cal read wrong");
	property p_parity;
		@(posedge clk_i) disable iff (!rst_n_i)
		(^cal1_q == 1'b0) && (^cal2_q == 1'b0);
	endproperty
	a_parity: assert property (p_parity) else $error("parity bit wrong");
	property p_no_write;
		@(posedge clk_i) disable iff (!rst_n_i)
		(wr_i && !last) |=> $stable(cal1_q) && $stable(cal2_q);
	endproperty
	a_no_write: assert property (p_no_write) else $error("write changed cal");
	property p_update;
		@(posedge clk_i) disable iff (!rst_n_i)
		(ce_i && last) |=> cal_update_o && cal1_q == $past(word1);
	endproperty
	a_update: assert property (p_update) else $error("average not stored");
	property p_late;
		@(posedge clk_i) disable iff (!rst_n_i)
		(ce_i && ref_begin) ##1 (ce_i && channel_one_end_input_i) |=> ref_late_o;
	endproperty
	a_late: assert property (p_late) else $error("short lead not flagged");
	property p_rvalid;
		@(posedge clk_i) disable iff (!rst_n_i)
		ce_i |=> rvalid_o == $past(sel_ok);
	endproperty
	a_rvalid: assert property (p_rvalid) else $error("read valid wrong");
	property p_hold;
		@(posedge clk_i) disable iff (!rst_n_i)
		!ce_i |=> $stable(cal1_q) && $stable(rdata_o);
	endproperty
	a_hold: assert property (p_hold) else $error("state moved while frozen");
	// a reference two cycles ahead is lead enough, no flag
	property p_lead_ok;
		@(posedge clk_i) disable iff (!rst_n_i)
		(ce_i && ref_begin) ##1 (ce_i && !ref_begin) ##1
		(ce_i && !ref_begin && channel_one_end_input_i) |=> !ref_late_o;
	endproperty
	a_lead_ok: assert property (p_lead_ok) else $error("adequate lead flagged");
	// read data holds between read strobes
	property p_rd_hold;
		@(posedge clk_i) disable iff (!rst_n_i)
		(ce_i && !sel_ok) |=> $stable(rdata_o);
	endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
	// addresses outside the two words read as zero
	property p_unmapped;
		@(posedge clk_i) disable iff (!rst_n_i)
		(ce_i && sel_ok && addr_i != `TCR_ADDR_CAL_FIRST && addr_i != `TCR_ADDR_CAL_SECOND)
		|=> rdata_o == 24'h000000;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	// calibration words only move when an average completes
	property p_cal_still;
		@(posedge clk_i) disable iff (!rst_n_i)
		(ce_i && !last) |=> $stable(cal1_q) && $stable(cal2_q);
	endproperty
	a_cal_still: assert property (p_cal_still) else $error("cal moved early");
	// each non-final pair advances the sample count by one
	property p_smp_step;
		@(posedge clk_i) disable iff (!rst_n_i)
		(ce_i && pair && !last) |=> smp_q == $past(smp_q) + 8'h01;
	endproperty
	a_smp_step: assert property (p_smp_step) else $error("sample count wrong");
	// second word takes its own average
	property p_update_second;
		@(posedge clk_i) disable iff (!rst_n_i)
		(ce_i && last) |=> cal2_q == $past(word2);
	endproperty
	a_update_second: assert property (p_update_second) else $error("second avg lost");
	// a consumed pair leaves no stale channel flag behind
	property p_pair_clear;
		@(posedge clk_i) disable iff (!rst_n_i)
		(ce_i && pair) |=> !got1_q && !got2_q;
	endproperty
	a_pair_clear: assert property (p_pair_clear) else $error("pair flag stuck");
endmodule
`default_nettype wire

// ---- tb/tcr_pulse_src.sv ----
// pulse source model: shared reference begin plus flight begin and end events
`timescale 1ns/1ps
`default_nettype none
module tcr_pulse_src (
	input wire logic clk_i,
	output logic ref_begin_o, // drives both channel begin inputs
	output logic flight_begin_event_o,
	output logic flight_end_event_o
);
	// idle low from time zero
	initial begin
		ref_begin_o = 1'b0;
		flight_begin_event_o = 1'b0;
		flight_end_event_o = 1'b0;
	end
	// --------------------------------------------------------
	// fire: reference at c0, flight begin at c0+t1, end at c0+t2
	// --------------------------------------------------------
	// t1 below 2 breaks the lead on purpose; callers keep t2 > t1
	task automatic fire(input int t1, input int t2);
		@(posedge clk_i);
		#1 ref_begin_o = 1'b1; // one common reference pulse
		@(posedge clk_i);
		#1 ref_begin_o = 1'b0;
		repeat (t1 - 1) @(posedge clk_i);
		#1 flight_begin_event_o = 1'b1; // flight begin ends channel one
		@(posedge clk_i);
		#1 flight_begin_event_o = 1'b0;
		repeat (t2 - t1 - 1) @(posedge clk_i);
		#1 flight_end_event_o = 1'b1; // flight end ends channel two
		@(posedge clk_i);
		#1 flight_end_event_o = 1'b0;
	endtask
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
// self-checking bench for the calibration result and combined measurement block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import tcr_pkg::*;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic cs_n = 1'b1; // active low select
	logic ce = 1'b1; // clock enable, dropped in the freeze scenario
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [5:0] addr = 6'h00;
	logic [23:0] wdata = 24'h000000;
	logic [2:0] avg_sel = 3'h0;
	logic ref_b, fl_b, fl_e, rvalid, ref_late, cal_upd;
	tcr_word_t rdata, v, w;
	int miscompares = 0;
	int cmp_count = 0;
	int upd_cnt = 0;
	int late_cnt = 0;
	int cycles = 0;
	always #4 clk_i = ~clk_i;
	tcr_pulse_src i_tcr_pulse_src (.clk_i(clk_i), .ref_begin_o(ref_b),
		.flight_begin_event_o(fl_b), .flight_end_event_o(fl_e));
	tcr_top i_tcr_top (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce),
		.channel_one_begin_input_i(ref_b), .channel_two_begin_input_i(ref_b),
		.channel_one_end_input_i(fl_b), .channel_two_end_input_i(fl_e),
		.avg_sel_i(avg_sel), .channel_chip_select_n_i(cs_n), .rd_i(rd), .wr_i(wr),
		.addr_i(addr), .wdata_i(wdata), .rdata_o(rdata), .rvalid_o(rvalid),
		.ref_late_o(ref_late), .cal_update_o(cal_upd));
	// --------------------------------------------------------
	// pulse counters and hang guard
	// --------------------------------------------------------
	always @(posedge clk_i) begin
		cycles++;
		if (cal_upd === 1'b1) upd_cnt++;
		if (ref_late === 1'b1) late_cnt++;
		if (cycles == 3000) begin
			miscompares++;
			wrap_up();
		end
	end
	task automatic wrap_up();
		if (miscompares == 0 && cmp_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input string name, input tcr_word_t e, input tcr_word_t s);
		cmp_count++;
		if (s !== e) begin
			miscompares++;
			$display("unexpected %s expected %h seen %h", name, e, s);
		end
	endtask
	// expected word: even parity over the value in the top bit
	function automatic tcr_word_t par(input int x);
		par = {^x[22:0], x[22:0]};
	endfunction
	// single read: held over the taking edge, answer one cycle later
	task automatic rd_reg(input logic [5:0] a, output tcr_word_t d);
		@(posedge clk_i);
		#1 {cs_n, rd, addr} = {1'b0, 1'b1, a};
		@(posedge clk_i);
		#1 {cs_n, rd} = 2'b10;
		chk("rvalid", 24'h000001, {23'h000000, rvalid});
		d = rdata;
	endtask
	task automatic wr_reg(input logic [5:0] a, input logic [23:0] d);
		@(posedge clk_i);
		#1 {cs_n, wr, addr, wdata} = {1'b0, 1'b1, a, d};
		@(posedge clk_i);
		#1 {cs_n, wr} = 2'b10;
	endtask
	task automatic wait_upd(input int n0);
		for (int i = 0; i < 40 && upd_cnt == n0; i++) @(posedge clk_i);
		chk("cal_update", 24'h000001, {23'h000000, upd_cnt > n0});
	endtask
	// --------------------------------------------------------
	// scenarios
	// --------------------------------------------------------
	task automatic t_reset_and_writes();
		for (int k = 0; k < 2; k++) begin
			rd_reg(6'h1b, v);
			chk("cal_first", 24'h000000, v);
			rd_reg(6'h1c, v);
			chk("cal_second", 24'h000000, v);
			rd_reg(6'h1d, v);
			chk("unmapped", 24'h000000, v);
			wr_reg(6'h1b, 24'h7fffff);
			wr_reg(6'h1c, 24'h123456);
		end
	endtask
	// two samples averaged, reads repeated to show they do not disturb
	task automatic t_average();
		int n;
		n = upd_cnt;
		avg_sel = 3'h1;
		i_tcr_pulse_src.fire(5, 9);
		repeat (4) @(posedge clk_i);
		i_tcr_pulse_src.fire(7, 10);
		wait_upd(n);
		rd_reg(6'h1b, v);
		rd_reg(6'h1b, w);
		chk("cal_first_avg", par((5 + 7) >> 1), v);
		chk("cal_first_again", v, w);
		rd_reg(6'h1c, w);
		chk("cal_second_avg", par((9 + 10) >> 1), w);
		chk("flight", 24'h000003, w - v);
	endtask
	// one-cycle flight with a proper lead, no late flag
	task automatic t_short_flight();
		int n;
		n = upd_cnt;
		avg_sel = 3'h0;
		late_cnt = 0;
		i_tcr_pulse_src.fire(3, 4);
		wait_upd(n);
		rd_reg(6'h1b, v);
		rd_reg(6'h1c, w);
		chk("short_flight", 24'h000001, w[22:0] - v[22:0]);
		chk("lead_ok", 24'h000000, late_cnt);
	endtask
	// reference one cycle ahead of flight begin is flagged, two cycles ahead is not
	task automatic t_late_ref();
		late_cnt = 0;
		i_tcr_pulse_src.fire(1, 3);
		repeat (6) @(posedge clk_i);
		chk("ref_late", 24'h000001, late_cnt);
		late_cnt = 0;
		i_tcr_pulse_src.fire(2, 3);
		repeat (6) @(posedge clk_i);
		chk("ref_lead_ok", 24'h000000, late_cnt);
	endtask
	// pulses while frozen must leave the words from the last run
	task automatic t_freeze();
		int n;
		n = upd_cnt;
		@(posedge clk_i);
		#1 ce = 1'b0;
		i_tcr_pulse_src.fire(3, 6);
		repeat (4) @(posedge clk_i);
		#1 ce = 1'b1;
		chk("frozen_update", 24'h000000, upd_cnt - n);
		rd_reg(6'h1b, v);
		chk("cal_first_frozen", par(2), v);
		rd_reg(6'h1c, v);
		chk("cal_second_frozen", par(3), v);
	endtask
	// reset in mid-run clears both words
	task automatic t_mid_reset();
		@(posedge clk_i);
		#1 rst_n_i = 1'b0;
		repeat (2) @(posedge clk_i);
		#1 rst_n_i = 1'b1;
		rd_reg(6'h1b, v);
		chk("cal_first_rst", 24'h000000, v);
		rd_reg(6'h1c, v);
		chk("cal_second_rst", 24'h000000, v);
	endtask
	initial begin
		repeat (20) @(posedge clk_i);
		#1 rst_n_i = 1'b1;
		t_reset_and_writes();
		t_average();
		t_short_flight();
		t_late_ref();
		t_freeze();
		t_mid_reset();
		wrap_up();
	end
endmodule
`default_nettype wire
